// ---- verilog/bmeu_params.svh ----
// Purpose: Constants of the branch and multiply execution unit
// Assumes: Included by the unit, never alone
// Notes:   Widths are sized to the signals that they meet
`ifndef BMEU_PARAMS_SVH
`define BMEU_PARAMS_SVH
// Status flag positions
`define BMEU_FLAG_C 3'h0
`define BMEU_FLAG_Z 3'h1
`define BMEU_FLAG_N 3'h2
`define BMEU_FLAG_V 3'h3
`define BMEU_FLAG_S 3'h4
`define BMEU_FLAG_H 3'h5
`define BMEU_FLAG_T 3'h6
`define BMEU_FLAG_I 3'h7
// Cycle counts
`define BMEU_CYC_ONE      3'h1
`define BMEU_CYC_PROD     3'h2
`define BMEU_CYC_REL_GOTO 3'h2
`define BMEU_CYC_REL_CALL 3'h3
`define BMEU_CYC_PTR_GOTO 3'h2
`define BMEU_CYC_PTR_CALL 3'h3
`define BMEU_CYC_ABS_GOTO 3'h3
`define BMEU_CYC_ABS_CALL 3'h4
`define BMEU_CYC_EXIT     3'h4
`define BMEU_CYC_BR_TAKEN 3'h2
`define BMEU_CYC_SKIP_ONE 3'h2
`define BMEU_CYC_SKIP_TWO 3'h3
// Program counter steps and bit-addressable I/O limit
`define BMEU_PC_STEP      22'h000001
`define BMEU_PC_SKIP_ONE  22'h000002
`define BMEU_PC_SKIP_TWO  22'h000003
`define BMEU_IO_BIT_MAX   6'h1F
`define BMEU_ONES_BYTE    8'hFF
`endif

// ---- verilog/bmeu_pkg.sv ----
// Purpose: Types of the branch and multiply execution unit
// Assumes: Opcode already decoded by the fetch stage
// Notes:   Program counter fields carry the widest supported width
`default_nettype none
package bmeu_pkg;
   typedef enum logic [5:0] {
      PROD_UNSIGNED, PROD_SIGNED, PROD_SIGNED_BY_UNSIGNED,
      FRACTION_PROD_UNSIGNED, FRACTION_PROD_SIGNED, FRACTION_PROD_MIXED,
      RELATIVE_GOTO, POINTER_GOTO, ABSOLUTE_GOTO,
      RELATIVE_SUB_INVOKE, POINTER_SUB_INVOKE, ABSOLUTE_SUB_INVOKE,
      SUBROUTINE_EXIT, INTERRUPT_EXIT,
      EQUAL_COMPARE_SKIP, REGISTER_COMPARE, COMPARE_THROUGH_CARRY, COMPARE_IMMEDIATE,
      REG_BIT_CLEAR_SKIP, REG_BIT_SET_SKIP, IO_BIT_CLEAR_SKIP, IO_BIT_SET_SKIP,
      FLAG_SET_BRANCH, FLAG_CLEAR_BRANCH, ZERO_SET_BRANCH, ZERO_CLEAR_BRANCH,
      CARRY_SET_BRANCH, CARRY_CLEAR_BRANCH, SAME_OR_HIGHER_BRANCH, LOWER_BRANCH,
      NEGATIVE_SET_BRANCH, NEGATIVE_CLEAR_BRANCH, SIGNED_GE_BRANCH, SIGNED_LT_BRANCH,
      HALF_CARRY_SET_BRANCH, HALF_CARRY_CLEAR_BRANCH,
      TRANSFER_BIT_SET_BRANCH, TRANSFER_BIT_CLEAR_BRANCH,
      OVERFLOW_SET_BRANCH, OVERFLOW_CLEAR_BRANCH,
      ZERO_REGISTER, FILL_ONES_REGISTER
   } bmeu_op_e;

   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_RUN  = 1'b1
   } bmeu_state_e;

   typedef struct packed {
      bmeu_op_e    op;
      logic [7:0]  rd;
      logic [7:0]  rr;
      logic [7:0]  imm;
      logic [2:0]  bitSel;
      logic [11:0] offset;
      logic [21:0] target;
      logic [15:0] pointer;
      logic [21:0] stackTop;
      logic [5:0]  ioAddr;
      logic [7:0]  ioData;
      logic        nextIsLong;
      logic [21:0] pc;
      logic [7:0]  flags;
   } bmeu_req_s;

   typedef struct packed {
      logic        done;
      logic        busy;
      logic        pcLoad;
      logic [21:0] pc;
      logic        flagsLoad;
      logic [7:0]  flags;
      logic        pairWrite;
      logic [15:0] pair;
      logic        regWrite;
      logic [7:0]  regData;
      logic        pushEn;
      logic [21:0] pushAddr;
      logic        ioRangeErr;
   } bmeu_res_s;
endpackage : bmeu_pkg
`default_nettype wire

// ---- verilog/bmeu_exec_unit.sv ----
// Purpose: Executes multiplies and program-flow instructions
// Assumes: One request at a time, taken only while busy is low
// Notes:   Results and strobes appear together with done
`include "bmeu_params.svh"
`default_nettype none
// Behaviour
// - Integer multiplies write 16-bit product to pair 1:0, flags Z,C, two cycles
// - Fractional multiplies shift product left one, flags Z,C, two cycles
// - Relative goto/call load PC+offset+1; goto two, call three cycles
// - Pointer goto/call load PC from pointer; goto two, call three
// - Absolute goto/call load target; goto three, call four cycles
// - Equal compare skips next instruction, PC +2 or +3, one to three cycles
// - Compares subtract unstored, update Z,N,V,C,H in one cycle
// - Register bit skips on chosen bit clear or set, no flags changed
// - I/O bit skips test an I/O bit, skip on clear or set
// - I/O bit skips reach only addresses 0x00 to 0x1F
// - Generic flag branches: taken PC+offset+1 in two, else one cycle
// - Named branches follow zero, carry and negative flags
// - Signed branches test N xor V: ge on 0, lt on 1
// - Half carry and transfer bit branches, one or two cycles
// - Overflow branches taken on V set or clear
module bmeu_exec_unit #(
   parameter int PC_W = 13
) (
   input  wire logic               mclk,
   input  wire logic               arst_n,
   input  wire logic               start,
   input  wire bmeu_pkg::bmeu_req_s req,
   output var  bmeu_pkg::bmeu_res_s res
);
   localparam logic [21:0] PC_MASK = 22'((64'h1 << PC_W) - 64'h1);

   if (PC_W < 12 || PC_W > 22) begin : g_bad_pc_w
      $error("PC_W must lie between 12 and 22");
   end

   // ****************************************
   // Branch condition decode
   // ****************************************
   function automatic logic branchTaken(input bmeu_pkg::bmeu_op_e op,
                                        input logic [2:0] bitSel,
                                        input logic [7:0] f);
      logic t;
      t = 1'b0;
      case (op)
         bmeu_pkg::FLAG_SET_BRANCH:           t = f[bitSel];
         bmeu_pkg::FLAG_CLEAR_BRANCH:         t = ~f[bitSel];
         bmeu_pkg::ZERO_SET_BRANCH:           t = f[`BMEU_FLAG_Z];
         bmeu_pkg::ZERO_CLEAR_BRANCH:         t = ~f[`BMEU_FLAG_Z];
         bmeu_pkg::CARRY_SET_BRANCH,
         bmeu_pkg::LOWER_BRANCH:              t = f[`BMEU_FLAG_C];
         bmeu_pkg::CARRY_CLEAR_BRANCH,
         bmeu_pkg::SAME_OR_HIGHER_BRANCH:     t = ~f[`BMEU_FLAG_C];
         bmeu_pkg::NEGATIVE_SET_BRANCH:       t = f[`BMEU_FLAG_N];
         bmeu_pkg::NEGATIVE_CLEAR_BRANCH:     t = ~f[`BMEU_FLAG_N];
         bmeu_pkg::SIGNED_GE_BRANCH:          t = ~(f[`BMEU_FLAG_N] ^ f[`BMEU_FLAG_V]);
         bmeu_pkg::SIGNED_LT_BRANCH:          t = f[`BMEU_FLAG_N] ^ f[`BMEU_FLAG_V];
         bmeu_pkg::HALF_CARRY_SET_BRANCH:     t = f[`BMEU_FLAG_H];
         bmeu_pkg::HALF_CARRY_CLEAR_BRANCH:   t = ~f[`BMEU_FLAG_H];
         bmeu_pkg::TRANSFER_BIT_SET_BRANCH:   t = f[`BMEU_FLAG_T];
         bmeu_pkg::TRANSFER_BIT_CLEAR_BRANCH: t = ~f[`BMEU_FLAG_T];
         bmeu_pkg::OVERFLOW_SET_BRANCH:       t = f[`BMEU_FLAG_V];
         bmeu_pkg::OVERFLOW_CLEAR_BRANCH:     t = ~f[`BMEU_FLAG_V];
         default:                             t = 1'b0;
      endcase
      return t;
   endfunction : branchTaken

   // ****************************************
   // Sequencer and result computation
   // ****************************************
   bmeu_pkg::bmeu_state_e state;
   bmeu_pkg::bmeu_state_e next_state;
   logic [2:0]            count;
   logic [2:0]            next_count;
   bmeu_pkg::bmeu_res_s   pend;
   bmeu_pkg::bmeu_res_s   next_pend;
   bmeu_pkg::bmeu_res_s   next_res;
   logic                  take;
   logic [21:0]           relTarget;

   assign take      = start && (state == bmeu_pkg::ST_IDLE);
   assign relTarget = (req.pc + {{10{req.offset[11]}}, req.offset} + `BMEU_PC_STEP) & PC_MASK;

   always_comb begin
      logic signed [17:0] prod;
      logic [15:0]        prodOut;
      logic [8:0]         diff;
      logic [7:0]         subtrahend;
      logic [7:0]         r;
      logic               cin;
      logic               skipCond;
      logic               isCompare;
      logic [2:0]         cyc;
      prod       = 18'h00000;
      prodOut    = 16'h0000;
      diff       = 9'h000;
      subtrahend = 8'h00;
      r          = 8'h00;
      cin        = 1'b0;
      skipCond   = 1'b0;
      isCompare  = 1'b0;
      cyc        = `BMEU_CYC_ONE;
      next_state = state;
      next_count = count;
      next_pend  = pend;
      next_res   = res;
      next_res.done       = 1'b0;
      next_res.pcLoad     = 1'b0;
      next_res.flagsLoad  = 1'b0;
      next_res.pairWrite  = 1'b0;
      next_res.regWrite   = 1'b0;
      next_res.pushEn     = 1'b0;
      next_res.ioRangeErr = 1'b0;
      case (state)
         bmeu_pkg::ST_IDLE: begin
            if (start) begin
               next_pend       = '0;
               next_pend.done  = 1'b1;
               next_pend.flags = req.flags;
               next_pend.pc    = (req.pc + `BMEU_PC_STEP) & PC_MASK;
               case (req.op)
                  bmeu_pkg::PROD_UNSIGNED, bmeu_pkg::PROD_SIGNED,
                  bmeu_pkg::PROD_SIGNED_BY_UNSIGNED,
                  bmeu_pkg::FRACTION_PROD_UNSIGNED, bmeu_pkg::FRACTION_PROD_SIGNED,
                  bmeu_pkg::FRACTION_PROD_MIXED: begin
                     prod = $signed({req.rd[7] & (req.op inside {bmeu_pkg::PROD_SIGNED,
                                     bmeu_pkg::PROD_SIGNED_BY_UNSIGNED,
                                     bmeu_pkg::FRACTION_PROD_SIGNED,
                                     bmeu_pkg::FRACTION_PROD_MIXED}), req.rd})
                          * $signed({req.rr[7] & (req.op inside {bmeu_pkg::PROD_SIGNED,
                                     bmeu_pkg::FRACTION_PROD_SIGNED}), req.rr});
                     prodOut = (req.op inside {bmeu_pkg::FRACTION_PROD_UNSIGNED,
                                bmeu_pkg::FRACTION_PROD_SIGNED, bmeu_pkg::FRACTION_PROD_MIXED})
                             ? {prod[14:0], 1'b0} : prod[15:0];
                     next_pend.pairWrite = 1'b1;
                     next_pend.pair      = prodOut;
                     next_pend.flagsLoad = 1'b1;
                     next_pend.flags[`BMEU_FLAG_C] = prod[15];
                     next_pend.flags[`BMEU_FLAG_Z] = (prodOut == 16'h0000);
                     cyc = `BMEU_CYC_PROD;
                  end
                  bmeu_pkg::RELATIVE_GOTO, bmeu_pkg::RELATIVE_SUB_INVOKE: begin
                     next_pend.pcLoad = 1'b1;
                     next_pend.pc     = relTarget;
                     next_pend.pushEn   = (req.op == bmeu_pkg::RELATIVE_SUB_INVOKE);
                     next_pend.pushAddr = (req.pc + `BMEU_PC_STEP) & PC_MASK;
                     cyc = next_pend.pushEn ? `BMEU_CYC_REL_CALL : `BMEU_CYC_REL_GOTO;
                  end
                  bmeu_pkg::POINTER_GOTO, bmeu_pkg::POINTER_SUB_INVOKE: begin
                     next_pend.pcLoad = 1'b1;
                     next_pend.pc     = {6'h00, req.pointer} & PC_MASK;
                     next_pend.pushEn   = (req.op == bmeu_pkg::POINTER_SUB_INVOKE);
                     next_pend.pushAddr = (req.pc + `BMEU_PC_STEP) & PC_MASK;
                     cyc = next_pend.pushEn ? `BMEU_CYC_PTR_CALL : `BMEU_CYC_PTR_GOTO;
                  end
                  bmeu_pkg::ABSOLUTE_GOTO, bmeu_pkg::ABSOLUTE_SUB_INVOKE: begin
                     next_pend.pcLoad = 1'b1;
                     next_pend.pc     = req.target & PC_MASK;
                     next_pend.pushEn   = (req.op == bmeu_pkg::ABSOLUTE_SUB_INVOKE);
                     next_pend.pushAddr = (req.pc + `BMEU_PC_SKIP_ONE) & PC_MASK;
                     cyc = next_pend.pushEn ? `BMEU_CYC_ABS_CALL : `BMEU_CYC_ABS_GOTO;
                  end
                  bmeu_pkg::SUBROUTINE_EXIT, bmeu_pkg::INTERRUPT_EXIT: begin
                     next_pend.pcLoad = 1'b1;
                     next_pend.pc     = req.stackTop & PC_MASK;
                     next_pend.flagsLoad = (req.op == bmeu_pkg::INTERRUPT_EXIT);
                     next_pend.flags[`BMEU_FLAG_I] = req.flags[`BMEU_FLAG_I]
                                                   | next_pend.flagsLoad;
                     cyc = `BMEU_CYC_EXIT;
                  end
                  bmeu_pkg::REGISTER_COMPARE, bmeu_pkg::COMPARE_THROUGH_CARRY,
                  bmeu_pkg::COMPARE_IMMEDIATE: begin
                     isCompare  = 1'b1;
                     subtrahend = (req.op == bmeu_pkg::COMPARE_IMMEDIATE) ? req.imm : req.rr;
                     cin  = (req.op == bmeu_pkg::COMPARE_THROUGH_CARRY) & req.flags[`BMEU_FLAG_C];
                     diff = {1'b0, req.rd} - {1'b0, subtrahend} - {8'h00, cin};
                     r    = diff[7:0];
                     next_pend.flagsLoad = 1'b1;
                     next_pend.flags[`BMEU_FLAG_C] = diff[8];
                     next_pend.flags[`BMEU_FLAG_N] = r[7];
                     next_pend.flags[`BMEU_FLAG_V] = (req.rd[7] & ~subtrahend[7] & ~r[7])
                                                   | (~req.rd[7] & subtrahend[7] & r[7]);
                     next_pend.flags[`BMEU_FLAG_S] = r[7] ^ next_pend.flags[`BMEU_FLAG_V];
                     next_pend.flags[`BMEU_FLAG_H] = (~req.rd[3] & subtrahend[3])
                                                   | (subtrahend[3] & r[3]) | (r[3] & ~req.rd[3]);
                     next_pend.flags[`BMEU_FLAG_Z] = (r == 8'h00) & ((req.op !=
                        bmeu_pkg::COMPARE_THROUGH_CARRY) | req.flags[`BMEU_FLAG_Z]);
                  end
                  bmeu_pkg::EQUAL_COMPARE_SKIP, bmeu_pkg::REG_BIT_CLEAR_SKIP,
                  bmeu_pkg::REG_BIT_SET_SKIP, bmeu_pkg::IO_BIT_CLEAR_SKIP,
                  bmeu_pkg::IO_BIT_SET_SKIP: begin
                     case (req.op)
                        bmeu_pkg::EQUAL_COMPARE_SKIP: skipCond = (req.rd == req.rr);
                        bmeu_pkg::REG_BIT_CLEAR_SKIP: skipCond = ~req.rr[req.bitSel];
                        bmeu_pkg::REG_BIT_SET_SKIP:   skipCond = req.rr[req.bitSel];
                        bmeu_pkg::IO_BIT_CLEAR_SKIP:  skipCond = ~req.ioData[req.bitSel];
                        bmeu_pkg::IO_BIT_SET_SKIP:    skipCond = req.ioData[req.bitSel];
                        default:                      skipCond = 1'b0;
                     endcase
                     if (req.op inside {bmeu_pkg::IO_BIT_CLEAR_SKIP, bmeu_pkg::IO_BIT_SET_SKIP}
                         && req.ioAddr > `BMEU_IO_BIT_MAX) begin
                        skipCond             = 1'b0;
                        next_pend.ioRangeErr = 1'b1;
                     end
                     next_pend.pcLoad = 1'b1;
                     if (skipCond) begin
                        next_pend.pc = (req.pc + (req.nextIsLong ? `BMEU_PC_SKIP_TWO
                                                 : `BMEU_PC_SKIP_ONE)) & PC_MASK;
                        cyc = req.nextIsLong ? `BMEU_CYC_SKIP_TWO : `BMEU_CYC_SKIP_ONE;
                     end
                  end
                  bmeu_pkg::ZERO_REGISTER, bmeu_pkg::FILL_ONES_REGISTER: begin
                     next_pend.regWrite = 1'b1;
                     if (req.op == bmeu_pkg::ZERO_REGISTER) begin
                        next_pend.flagsLoad = 1'b1;
                        next_pend.flags[`BMEU_FLAG_Z] = 1'b1;
                        next_pend.flags[`BMEU_FLAG_N] = 1'b0;
                        next_pend.flags[`BMEU_FLAG_V] = 1'b0;
                        next_pend.flags[`BMEU_FLAG_S] = 1'b0;
                     end else begin
                        next_pend.regData = `BMEU_ONES_BYTE;
                     end
                  end
                  default: begin
                     next_pend.pcLoad = 1'b1;
                     if (branchTaken(req.op, req.bitSel, req.flags)) begin
                        next_pend.pc = relTarget;
                        cyc = `BMEU_CYC_BR_TAKEN;
                     end
                  end
               endcase
               next_count    = cyc - 3'h1;
               next_state    = bmeu_pkg::ST_RUN;
               next_res.busy = 1'b1;
            end
         end
         bmeu_pkg::ST_RUN: begin
            if (count == 3'h0) begin
               next_res   = pend;
               next_state = bmeu_pkg::ST_IDLE;
            end else begin
               next_count = count - 3'h1;
            end
         end
         default: begin
            next_state = bmeu_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         state <= bmeu_pkg::ST_IDLE;
         count <= 3'h0;
         pend  <= '0;
         res   <= '0;
      end else begin
         state <= next_state;
         count <= next_count;
         pend  <= next_pend;
         res   <= next_res;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);

   prod_two_cycles_a: assert property (
      take && req.op == bmeu_pkg::PROD_UNSIGNED |=> !res.done ##1 !res.done ##1 res.done
      && res.pairWrite && res.pair == 16'($past(req.rd, 3) * $past(req.rr, 3)))
      else $error("unsigned product wrong or late");
   frac_shift_a: assert property (
      take && req.op == bmeu_pkg::FRACTION_PROD_UNSIGNED |-> ##3 res.done
      && res.pair == 16'({8'h00, $past(req.rd, 3)} * {8'h00, $past(req.rr, 3)} << 1))
      else $error("fractional product not shifted");
   rel_goto_a: assert property (
      take && req.op == bmeu_pkg::RELATIVE_GOTO |-> ##3 res.pcLoad && !res.flagsLoad
      && res.pc == $past(relTarget, 3))
      else $error("relative goto target or timing wrong");
   abs_call_a: assert property (
      take && req.op == bmeu_pkg::ABSOLUTE_SUB_INVOKE |=> !res.done [*4] ##1 res.done
      && res.pushEn && res.pc == ($past(req.target, 5) & PC_MASK))
      else $error("absolute call not four cycles");
   int_exit_a: assert property (
      take && req.op == bmeu_pkg::INTERRUPT_EXIT |-> ##5 res.pcLoad && res.flagsLoad
      && res.flags[`BMEU_FLAG_I])
      else $error("interrupt exit did not set I");
   compare_one_a: assert property (
      take && req.op == bmeu_pkg::REGISTER_COMPARE |-> ##2 res.done && res.flagsLoad
      && !res.pairWrite && !res.regWrite
      && res.flags[`BMEU_FLAG_Z] == ($past(req.rd, 2) == $past(req.rr, 2)))
      else $error("compare result wrong");
   io_range_a: assert property (
      take && req.op inside {bmeu_pkg::IO_BIT_CLEAR_SKIP, bmeu_pkg::IO_BIT_SET_SKIP}
      && req.ioAddr > `BMEU_IO_BIT_MAX |-> ##2 res.done && res.ioRangeErr
      && res.pc == (($past(req.pc, 2) + `BMEU_PC_STEP) & PC_MASK))
      else $error("out of range I/O bit skipped");
   branch_not_a: assert property (
      take && !branchTaken(req.op, req.bitSel, req.flags) && req.op inside
      {[bmeu_pkg::FLAG_SET_BRANCH:bmeu_pkg::OVERFLOW_CLEAR_BRANCH]} |-> ##2 res.done
      && res.pc == (($past(req.pc, 2) + `BMEU_PC_STEP) & PC_MASK))
      else $error("untaken branch not one cycle");
   zero_reg_a: assert property (
      take && req.op == bmeu_pkg::ZERO_REGISTER |-> ##2 res.regWrite && res.regData == 8'h00
      && res.flags[`BMEU_FLAG_Z] && !res.flags[`BMEU_FLAG_N])
      else $error("zero register wrong");
endmodule : bmeu_exec_unit
`default_nettype wire

// ---- testbench/bmeu_core_model.sv ----
// Purpose: Core-side model holding program counter and status flags
// Assumes: Load strobes are valid only in the done cycle
// Notes:   Gives the bench a running program counter
`default_nettype none
module bmeu_core_model (
   input  wire logic                mclk,
   input  wire logic                arst_n,
   input  wire bmeu_pkg::bmeu_res_s res,
   output logic [21:0]              pc,
   output logic [7:0]               flags
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [21:0] next_pc;
   logic [7:0]  next_flags;

   always_comb begin
      next_pc    = res.pcLoad ? res.pc : pc;
      next_flags = res.flagsLoad ? res.flags : flags;
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         pc    <= 22'h000000;
         flags <= 8'h00;
      end else begin
         pc    <= next_pc;
         flags <= next_flags;
      end
   end
endmodule : bmeu_core_model
`default_nettype wire

// ---- testbench/branch_multiply_exec_unit_test.sv ----
// Purpose: Self-checking bench for the execution unit
// Assumes: One op at a time, next start in the done cycle
// Notes:   Program counter width reduced to 16 bits
`default_nettype none
module branch_multiply_exec_unit_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [21:0] NOPC = 22'h3FFFFF;
   localparam logic [21:0] MSK  = 22'h00FFFF;
   logic                mclk;
   logic                arst_n;
   logic                start;
   bmeu_pkg::bmeu_req_s req;
   bmeu_pkg::bmeu_res_s res;
   logic [21:0]         corePc;
   logic [31:0]         seed;
   int                  err_total;
   int                  tests_run;

   bmeu_exec_unit #(.PC_W(16)) dut (.mclk(mclk), .arst_n(arst_n), .start(start), .req(req),
      .res(res));
   bmeu_core_model core (.mclk(mclk), .arst_n(arst_n), .res(res), .pc(corePc), .flags());

   always #4 mclk = ~mclk;

   function automatic logic [31:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction : rnd

   // Expected {busy, cycles, pc, flags, data, push, err}
   function automatic logic [73:0] want(bmeu_pkg::bmeu_req_s q);
      logic [3:0]  c;
      logic [21:0] p, u, o;
      logic [7:0]  f, b, r;
      logic [15:0] d;
      logic [17:0] m;
      logic [8:0]  s;
      logic        t, e, sd, sr;
      c = 4'h1;
      p = NOPC;
      f = q.flags;
      d = 16'h0000;
      u = 22'h000000;
      e = 1'b0;
      t = 1'b0;
      o = q.pc + {{10{q.offset[11]}}, q.offset} + 22'h000001;
      b = (q.op == bmeu_pkg::COMPARE_IMMEDIATE) ? q.imm : q.rr;
      sd = q.op inside {bmeu_pkg::PROD_SIGNED, bmeu_pkg::PROD_SIGNED_BY_UNSIGNED,
                        bmeu_pkg::FRACTION_PROD_SIGNED, bmeu_pkg::FRACTION_PROD_MIXED};
      sr = q.op inside {bmeu_pkg::PROD_SIGNED, bmeu_pkg::FRACTION_PROD_SIGNED};
      m = {{10{sd & q.rd[7]}}, q.rd} * {{10{sr & q.rr[7]}}, q.rr};
      s = {1'b0, q.rd} - {1'b0, b} - {8'h00, q.op == bmeu_pkg::COMPARE_THROUGH_CARRY && f[0]};
      r = s[7:0];
      if (q.op <= bmeu_pkg::FRACTION_PROD_MIXED) begin
         c = 4'h2;
         d = (q.op >= bmeu_pkg::FRACTION_PROD_UNSIGNED) ? {m[14:0], 1'b0} : m[15:0];
         f[0] = m[15];
         f[1] = d == 16'h0000;
      end
      case (q.op)
         bmeu_pkg::RELATIVE_GOTO: begin c = 4'h2; p = o; end
         bmeu_pkg::RELATIVE_SUB_INVOKE: begin c = 4'h3; p = o; u = q.pc + 22'h000001; end
         bmeu_pkg::POINTER_GOTO: begin c = 4'h2; p = {6'h00, q.pointer}; end
         bmeu_pkg::POINTER_SUB_INVOKE: begin c = 4'h3; p = {6'h00, q.pointer}; u = q.pc + 22'h000001; end
         bmeu_pkg::ABSOLUTE_GOTO: begin c = 4'h3; p = q.target; end
         bmeu_pkg::ABSOLUTE_SUB_INVOKE: begin c = 4'h4; p = q.target; u = q.pc + 22'h000002; end
         bmeu_pkg::SUBROUTINE_EXIT: begin c = 4'h4; p = q.stackTop; end
         bmeu_pkg::INTERRUPT_EXIT: begin c = 4'h4; p = q.stackTop; f[7] = 1'b1; end
         bmeu_pkg::REGISTER_COMPARE, bmeu_pkg::COMPARE_THROUGH_CARRY,
         bmeu_pkg::COMPARE_IMMEDIATE: begin
            f[0] = s[8];
            f[1] = (r == 8'h00) && (q.op != bmeu_pkg::COMPARE_THROUGH_CARRY || q.flags[1]);
            f[2] = r[7];
            f[3] = (q.rd[7] & ~b[7] & ~r[7]) | (~q.rd[7] & b[7] & r[7]);
            f[4] = f[2] ^ f[3];
            f[5] = (~q.rd[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~q.rd[3]);
         end
         bmeu_pkg::EQUAL_COMPARE_SKIP: t = q.rd == q.rr;
         bmeu_pkg::REG_BIT_CLEAR_SKIP, bmeu_pkg::REG_BIT_SET_SKIP:
            t = q.rr[q.bitSel] == (q.op == bmeu_pkg::REG_BIT_SET_SKIP);
         bmeu_pkg::IO_BIT_CLEAR_SKIP, bmeu_pkg::IO_BIT_SET_SKIP: begin
            e = q.ioAddr > 6'h1F;
            t = !e && (q.ioData[q.bitSel] == (q.op == bmeu_pkg::IO_BIT_SET_SKIP));
         end
         bmeu_pkg::FLAG_SET_BRANCH: t = f[q.bitSel];
         bmeu_pkg::FLAG_CLEAR_BRANCH: t = !f[q.bitSel];
         bmeu_pkg::ZERO_SET_BRANCH: t = f[1];
         bmeu_pkg::ZERO_CLEAR_BRANCH: t = !f[1];
         bmeu_pkg::CARRY_SET_BRANCH, bmeu_pkg::LOWER_BRANCH: t = f[0];
         bmeu_pkg::CARRY_CLEAR_BRANCH, bmeu_pkg::SAME_OR_HIGHER_BRANCH: t = !f[0];
         bmeu_pkg::NEGATIVE_SET_BRANCH: t = f[2];
         bmeu_pkg::NEGATIVE_CLEAR_BRANCH: t = !f[2];
         bmeu_pkg::SIGNED_GE_BRANCH: t = !(f[2] ^ f[3]);
         bmeu_pkg::SIGNED_LT_BRANCH: t = f[2] ^ f[3];
         bmeu_pkg::HALF_CARRY_SET_BRANCH: t = f[5];
         bmeu_pkg::HALF_CARRY_CLEAR_BRANCH: t = !f[5];
         bmeu_pkg::TRANSFER_BIT_SET_BRANCH: t = f[6];
         bmeu_pkg::TRANSFER_BIT_CLEAR_BRANCH: t = !f[6];
         bmeu_pkg::OVERFLOW_SET_BRANCH: t = f[3];
         bmeu_pkg::OVERFLOW_CLEAR_BRANCH: t = !f[3];
         bmeu_pkg::ZERO_REGISTER: f[4:1] = 4'h1;
         bmeu_pkg::FILL_ONES_REGISTER: d = 16'h00FF;
         default: ;
      endcase
      if (q.op inside {bmeu_pkg::EQUAL_COMPARE_SKIP,
                       [bmeu_pkg::REG_BIT_CLEAR_SKIP:bmeu_pkg::IO_BIT_SET_SKIP]}) begin
         c = t ? 4'h2 + {3'h0, q.nextIsLong} : 4'h1;
         p = q.pc + {18'h00000, c};
      end
      if (q.op inside {[bmeu_pkg::FLAG_SET_BRANCH:bmeu_pkg::OVERFLOW_CLEAR_BRANCH]}) begin
         c = t ? 4'h2 : 4'h1;
         p = t ? o : q.pc + 22'h000001;
      end
      if (p != NOPC) p = p & MSK;
      return {1'b0, c, p, f, d, u & MSK, e};
   endfunction : want

   task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic give_verdict();
      if (err_total == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : give_verdict

   task automatic runOp(input bmeu_pkg::bmeu_req_s q, input logic hold);
      logic [73:0] ex;
      logic [3:0]  c;
      ex = want(q);
      req = q;
      start = 1'b1;
      @(posedge mclk);
      #1;
      // Refused start while busy
      start = hold && ex[72:69] > 4'h1;
      req.op = bmeu_pkg::FILL_ONES_REGISTER;
      c = 4'h0;
      do begin
         @(posedge mclk);
         #1;
         start = 1'b0;
         c++;
      end while (res.done !== 1'b1 && c < 4'h8);
      if (res.done !== 1'b1) begin
         err_total++;
         give_verdict();
      end
      chk(96'({res.busy, c, res.pcLoad ? res.pc : NOPC, res.flagsLoad ? res.flags : q.flags,
               res.pairWrite ? res.pair : {8'h00, res.regData & {8{res.regWrite}}},
               res.pushEn ? res.pushAddr : 22'h000000, res.ioRangeErr}), 96'(ex));
   endtask : runOp

   initial begin
      logic [159:0]        w;
      bmeu_pkg::bmeu_req_s q;
      mclk = 1'b0;
      arst_n = 1'b0;
      start = 1'b0;
      req = '0;
      seed = 32'hF3113620;
      err_total = 0;
      tests_run = 0;
      repeat (2) @(posedge mclk);
      #1;
      arst_n = 1'b1;
      for (int p = 0; p < 12; p++) begin
         for (int i = 0; i < 42; i++) begin
            w = {rnd(), rnd(), rnd(), rnd(), rnd()};
            q = w[149:0];
            q.op = bmeu_pkg::bmeu_op_e'(6'(i));
            q.pc = corePc;
            if (w[150]) q.rr = q.rd;
            if (p < 2) begin
               q.rd = p ? 8'hFF : 8'h80;
               q.rr = p ? 8'h01 : 8'h80;
               q.imm = 8'hFF;
               q.ioAddr = p ? 6'h20 : 6'h1F;
               q.flags = p ? 8'h00 : 8'hFF;
               q.nextIsLong = p[0];
            end
            runOp(q, w[151]);
         end
         if (p == 5) begin
            arst_n = 1'b0;
            #2;
            chk(96'(res), 96'h0);
            @(posedge mclk);
            #1;
            arst_n = 1'b1;
         end
      end
      give_verdict();
   end
endmodule : branch_multiply_exec_unit_test
`default_nettype wire
